// ==== rtl/pprm_route_mux.sv ====
/*
 * Peripheral pin routing multiplexer: four routing registers on APB steer
 * event lines, lookup tables and serial channels onto port pins.
 * Assumes pin inputs are asynchronous and peripheral signals share clk.
 */
// The APB interface to the registers was decided locally.
// Behaviour
// [RULE1] Event line G goes to pin G2 when clear, G7 when set.
// [RULE2] Event line F goes to pin F2 when clear; set leaves it unrouted.
// [RULE3] Event line E goes to pin E2 when clear, E7 when set.
// [RULE4] Event line D goes to pin D2 when clear, D7 when set.
// [RULE5] Event line C goes to pin C2 when clear, C7 when set.
// [RULE6] Event line B goes to pin B2 when clear, B7 when set.
// [RULE7] Event line A goes to pin A2 when clear, A7 when set.
// [RULE8] Table 5 output on G3 or G6; inputs always G0 to G2.
// [RULE9] Table 4 output on B3 or B6; inputs always B0 to B2.
// [RULE10] Table 3 uses F3 and F0 to F2 when clear; set is unrouted.
// [RULE11] Table 2 output on D3 or D6; inputs always D0 to D2.
// [RULE12] Table 1 output on C3 or C6; inputs always C0 to C2.
// [RULE13] Table 0 output on A3 or A6; inputs always A0 to A2.
// [RULE14] Serial 3 field bits 7:6 picks B0-B3 or B4-B7; code 2 reserved.
// [RULE15] Serial 2 field bits 5:4 picks F0-F3, or only transmit/receive on F4-F5.
// [RULE16] Serial 1 field bits 3:2 picks C0-C3 or C4-C7.
// [RULE17] Serial 0 field bits 1:0 picks A0-A3 or A4-A7.
// [RULE18] Serial 5 field bits 3:2 of second register picks G0-G3 or G4-G7.
// [RULE19] Serial field code 3 connects none of the channel's signals.
// [RULE20] Registers enable, disable or move peripheral functions between pin positions.
// [RULE21] Unused register bits read zero and ignore writes.
// [RULE22] Writes steer pins from the next cycle; undefined codes disconnect.
`timescale 1ns/10ps

module pprm_route_mux #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  logic                                   clk,
   input  logic                                   rst,
   // APB slave
   input  logic                                   psel,
   input  logic                                   penable,
   input  logic                                   pwrite,
   input  logic [ADDR_W-1:0]                      paddr,
   input  logic [31:0]                            pwdata,
   input  logic [3:0]                             pstrb,
   output logic [31:0]                            prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // Peripheral side
   input  logic [pprm_pkg::NUM_EVT-1:0]           eventLine,
   input  logic [pprm_pkg::NUM_LUT-1:0]           lutOut,
   output logic [pprm_pkg::NUM_LUT-1:0][2:0]      lutIn,
   input  pprm_pkg::pprm_ser_drive_s [5:0]        serDrive,
   output logic [pprm_pkg::NUM_SER-1:0]           serRx,
   output logic [pprm_pkg::NUM_SER-1:0]           serClkIn,
   // Port pins, port A first
   input  logic [pprm_pkg::NUM_PORTS-1:0][7:0]    pinIn,
   output logic [pprm_pkg::NUM_PORTS-1:0][7:0]    pinOut,
   output logic [pprm_pkg::NUM_PORTS-1:0][7:0]    pinOe
);

   // The unmapped test needs at least one address bit above the word index
   if (ADDR_W < 5) begin : g_addr_check
      $error("ADDR_W must be at least 5");
   end

   pprm_pkg::pprm_state_s s;
   pprm_pkg::pprm_state_s n;

   logic [1:0] regIdx;
   logic       regHit;

   // Word index of the access; anything above index 3 is unmapped
   assign regIdx = paddr[3:2];
   assign regHit = (paddr[ADDR_W-1:4] == '0);

   function automatic logic [7:0] regMask(input logic [1:0] idx);
      logic [7:0] m;
      m = pprm_pkg::SER_ROUTE_B_MASK;
      unique case (idx)
         pprm_pkg::EVT_ROUTE_IDX:   m = pprm_pkg::EVT_ROUTE_MASK;
         pprm_pkg::LUT_ROUTE_IDX:   m = pprm_pkg::LUT_ROUTE_MASK;
         pprm_pkg::SER_ROUTE_A_IDX: m = pprm_pkg::SER_ROUTE_A_MASK;
         pprm_pkg::SER_ROUTE_B_IDX: m = pprm_pkg::SER_ROUTE_B_MASK;
      endcase
      return m;
   endfunction

   // Two-bit routing field of a serial channel
   function automatic logic [1:0] serField(input logic [3:0][7:0] r,
                                           input int ch);
      logic [1:0] f;
      if (ch < pprm_pkg::SER_A_CHANS) begin
         f = r[pprm_pkg::SER_ROUTE_A_IDX][2*ch +: 2];
      end else begin
         f = r[pprm_pkg::SER_ROUTE_B_IDX][2*(ch-pprm_pkg::SER_A_CHANS) +: 2];
      end
      return f;
   endfunction

   always_comb begin
      logic [2:0] port;
      logic [2:0] pin;
      logic [1:0] field;
      logic       sel;
      port  = 3'h0;
      pin   = 3'h0;
      field = 2'h0;
      sel   = 1'b0;
      n = s;

      // Pins pass two flops before any routing logic sees them
      n.pinMeta = pinIn;
      n.pinSync = s.pinMeta;

      // One wait-free access phase: answer prepared during setup
      n.pready  = psel & ~penable;
      n.pslverr = 1'b0;
      if (psel && !penable) begin
         n.pslverr = ~regHit;
         n.prdata  = 32'h0;
         if (regHit && !pwrite) begin
            n.prdata = {24'h0, s.route[regIdx] & regMask(regIdx)};  // [RULE21]
         end
      end
      if (psel && penable && s.pready && pwrite && regHit && pstrb[0]) begin
         n.route[regIdx] = pwdata[7:0] & regMask(regIdx);  // [RULE21]
      end

      // Routing follows the value being written, so pins move on the
      // same edge that the register takes it [RULE22] [RULE20]
      n.pinOut   = '0;
      n.pinOe    = '0;
      n.lutIn    = '0;
      n.serRx    = '0;
      n.serClkIn = '0;

      // Event line i sits on port i [RULE1] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7]
      for (int i = 0; i < pprm_pkg::NUM_EVT; i++) begin
         sel = n.route[pprm_pkg::EVT_ROUTE_IDX][i];
         if (!(i == pprm_pkg::EVT_NO_ALT && sel)) begin  // [RULE2]
            pin = sel ? pprm_pkg::EVT_PIN_ALT : pprm_pkg::EVT_PIN_DEF;
            n.pinOut[i][pin] = eventLine[i];
            n.pinOe[i][pin]  = 1'b1;
         end
      end

      // Lookup tables [RULE8] [RULE9] [RULE11] [RULE12] [RULE13]
      for (int k = 0; k < pprm_pkg::NUM_LUT; k++) begin
         sel  = n.route[pprm_pkg::LUT_ROUTE_IDX][k];
         port = pprm_pkg::LUT_PORT[k];
         if (!(k == pprm_pkg::LUT_NO_ALT && sel)) begin  // [RULE10] [RULE22]
            pin = sel ? pprm_pkg::LUT_OUT_ALT : pprm_pkg::LUT_OUT_DEF;
            n.pinOut[port][pin] = lutOut[k];
            n.pinOe[port][pin]  = 1'b1;
            n.lutIn[k]          = s.pinSync[port][2:0];
         end
      end

      // Serial channels come last, so they win a pin shared with the above.
      // Channel 4 has a stored field but no pin routing here.
      for (int c = 0; c < pprm_pkg::NUM_SER; c++) begin
         field = serField(n.route, c);
         port  = pprm_pkg::SER_PORT[c];
         // Reserved and none codes leave the channel off every pin [RULE19] [RULE22]
         if (c != pprm_pkg::SER_UNROUTED &&
             (field == pprm_pkg::SER_DEFAULT || field == pprm_pkg::SER_ALT)) begin
            // [RULE14] [RULE16] [RULE17] [RULE18]
            pin = (field == pprm_pkg::SER_ALT) ? pprm_pkg::SER_BASE_ALT
                                               : pprm_pkg::SER_BASE_DEF;
            n.pinOut[port][pin]        = serDrive[c].tx;
            n.pinOe[port][pin]         = 1'b1;
            n.serRx[c]                 = s.pinSync[port][pin + 3'h1];
            // Short alternate group carries no clock or direction [RULE15]
            if (!(c == pprm_pkg::SER_SHORT_ALT && field == pprm_pkg::SER_ALT)) begin
               n.pinOut[port][pin + 3'h2] = serDrive[c].clkOut;
               n.pinOe[port][pin + 3'h2]  = serDrive[c].clkOe;
               n.serClkIn[c]              = s.pinSync[port][pin + 3'h2];
               n.pinOut[port][pin + 3'h3] = serDrive[c].dir;
               n.pinOe[port][pin + 3'h3]  = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.route[pprm_pkg::EVT_ROUTE_IDX]   <= pprm_pkg::EVT_ROUTE_RST;
         s.route[pprm_pkg::LUT_ROUTE_IDX]   <= pprm_pkg::LUT_ROUTE_RST;
         s.route[pprm_pkg::SER_ROUTE_A_IDX] <= pprm_pkg::SER_ROUTE_A_RST;
         s.route[pprm_pkg::SER_ROUTE_B_IDX] <= pprm_pkg::SER_ROUTE_B_RST;
      end else begin
         s <= n;
      end
   end

   assign prdata   = s.prdata;
   assign pready   = s.pready;
   assign pslverr  = s.pslverr;
   assign lutIn    = s.lutIn;
   assign serRx    = s.serRx;
   assign serClkIn = s.serClkIn;
   assign pinOut   = s.pinOut;
   assign pinOe    = s.pinOe;

endmodule // pprm_route_mux

// ==== rtl/pprm_pkg.sv ====
/*
 * Constants and carrier types of the peripheral pin routing multiplexer.
 * Assumes ports A to G are numbered 0 to 6 and each holds eight pins.
 */
package pprm_pkg;

   // Geometry
   localparam int NUM_PORTS = 7;
   localparam int NUM_EVT   = 7;
   localparam int NUM_LUT   = 6;
   localparam int NUM_SER   = 6;

   // Register indices; the byte address is four times the index
   localparam logic [1:0] EVT_ROUTE_IDX  = 2'h0;
   localparam logic [1:0] LUT_ROUTE_IDX  = 2'h1;
   localparam logic [1:0] SER_ROUTE_A_IDX = 2'h2;
   localparam logic [1:0] SER_ROUTE_B_IDX = 2'h3;

   // Reset values
   localparam logic [7:0] EVT_ROUTE_RST   = 8'h00;
   localparam logic [7:0] LUT_ROUTE_RST   = 8'h00;
   localparam logic [7:0] SER_ROUTE_A_RST = 8'h00;
   localparam logic [7:0] SER_ROUTE_B_RST = 8'h00;

   // Implemented bits of each register
   localparam logic [7:0] EVT_ROUTE_MASK   = 8'h7f;
   localparam logic [7:0] LUT_ROUTE_MASK   = 8'h3f;
   localparam logic [7:0] SER_ROUTE_A_MASK = 8'hff;
   localparam logic [7:0] SER_ROUTE_B_MASK = 8'h0f;

   // Event line pin positions; line F has no alternate position
   localparam logic [2:0] EVT_PIN_DEF = 3'h2;
   localparam logic [2:0] EVT_PIN_ALT = 3'h7;
   localparam int         EVT_NO_ALT  = 5;

   // Lookup table output positions; inputs always sit on pins 0 to 2
   localparam logic [2:0] LUT_OUT_DEF = 3'h3;
   localparam logic [2:0] LUT_OUT_ALT = 3'h6;
   localparam int         LUT_NO_ALT  = 3;
   localparam logic [5:0][2:0] LUT_PORT = {3'h6, 3'h1, 3'h5, 3'h3, 3'h2, 3'h0};

   // Serial channel field codes and pin groups
   localparam logic [1:0] SER_DEFAULT = 2'h0;
   localparam logic [1:0] SER_ALT     = 2'h1;
   localparam logic [1:0] SER_RSVD    = 2'h2;
   localparam logic [1:0] SER_NONE    = 2'h3;
   localparam logic [2:0] SER_BASE_DEF = 3'h0;
   localparam logic [2:0] SER_BASE_ALT = 3'h4;
   localparam int         SER_SHORT_ALT = 2;
   localparam int         SER_UNROUTED  = 4;
   localparam int         SER_A_CHANS   = 4;
   localparam logic [5:0][2:0] SER_PORT = {3'h6, 3'h4, 3'h1, 3'h5, 3'h2, 3'h0};

   // What a serial channel drives toward its pins
   typedef struct packed {
      logic tx;
      logic clkOut;
      logic clkOe;
      logic dir;
   } pprm_ser_drive_s;

   // Whole state of the multiplexer
   typedef struct packed {
      logic [3:0][7:0]           route;
      logic [NUM_PORTS-1:0][7:0] pinMeta;
      logic [NUM_PORTS-1:0][7:0] pinSync;
      logic [NUM_PORTS-1:0][7:0] pinOut;
      logic [NUM_PORTS-1:0][7:0] pinOe;
      logic [NUM_LUT-1:0][2:0]   lutIn;
      logic [NUM_SER-1:0]        serRx;
      logic [NUM_SER-1:0]        serClkIn;
      logic [31:0]               prdata;
      logic                      pready;
      logic                      pslverr;
   } pprm_state_s;

endpackage

// ==== verification/pprm_route_mux_sva.sv ====
/* Port checker for pprm_route_mux, bound to every instance.
   Assumes zero-wait APB, one-cycle registered pin outputs and three-flop pin inputs. */
`timescale 1ns/10ps
module pprm_route_mux_sva #(
   parameter int ADDR_W = 12
) (
   // Clock, reset and bus
   input wire logic                            clk,
   input wire logic                            rst,
   input wire logic                            psel,
   input wire logic                            penable,
   input wire logic                            pwrite,
   input wire logic [ADDR_W-1:0]               paddr,
   input wire logic [31:0]                     pwdata,
   input wire logic [3:0]                      pstrb,
   input wire logic [31:0]                     prdata,
   input wire logic                            pready,
   input wire logic                            pslverr,
   // Peripherals and pins
   input wire logic [6:0]                      eventLine,
   input wire logic [5:0][2:0]                 lutIn,
   input wire pprm_pkg::pprm_ser_drive_s [5:0] serDrive,
   input wire logic [6:0][7:0]                 pinIn,
   input wire logic [6:0][7:0]                 pinOut,
   input wire logic [6:0][7:0]                 pinOe
);
   localparam logic [3:0][7:0] MSK = {pprm_pkg::SER_ROUTE_B_MASK, pprm_pkg::SER_ROUTE_A_MASK,
                                      pprm_pkg::LUT_ROUTE_MASK, pprm_pkg::EVT_ROUTE_MASK};
   logic [3:0][7:0] rg;
   logic [1:0]      age;
   // Shadow registers, so pin checks need no hierarchical peeking
   always_ff @(posedge clk) begin
      if (rst) begin
         rg <= '0;
         age <= 2'h0;
      end else begin
         if (age != 2'h3) age <= age + 2'h1;
         if (psel && penable && pready && pwrite && pstrb[0] && paddr[ADDR_W-1:4] == '0)
            rg[paddr[3:2]] <= pwdata[7:0] & MSK[paddr[3:2]];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_back; pready && !pwrite && !pslverr |-> prdata == {24'h0, rg[paddr[3:2]]}; endproperty
   a_back: assert property (p_back) else $error("read data wrong");
   property p_unmap; pready && paddr[ADDR_W-1:4] != '0 |-> pslverr && prdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
   property p_evtG;
      age == 2'h3 && rg[0][6] && rg[3][3:2] != 2'h1 |-> pinOe[6][7] && pinOut[6][7] == $past(eventLine[6]);
   endproperty
   a_evtG: assert property (p_evtG) else $error("event G not on pin 7");
   property p_evtF; rg[0][5] && rg[2][5:4] == 2'h3 |-> !pinOe[5][2]; endproperty
   a_evtF: assert property (p_evtF) else $error("F pin 2 driven");
   property p_lutIn; age == 2'h3 |-> lutIn[4] == $past(pinIn[1][2:0], 3); endproperty
   a_lutIn: assert property (p_lutIn) else $error("table 4 inputs wrong");
   property p_lookup_table_3; rg[1][3] && $past(rg[1][3]) |-> lutIn[3] == 3'h0; endproperty
   a_lookup_table_3: assert property (p_lookup_table_3) else $error("table 3 still routed");
   property p_serAlt;
      age == 2'h3 && rg[2][1:0] == 2'h1 |-> pinOe[0][4] && pinOut[0][4] == $past(serDrive[0].tx);
   endproperty
   a_serAlt: assert property (p_serAlt) else $error("serial 0 transmit not on A4");
   c_evtF: cover property (rg[0][5] && rg[2][5:4] == 2'h3);
   c_err: cover property (pready && pslverr);
   c_alt: cover property (age == 2'h3 && rg[2][1:0] == 2'h1);
endmodule // pprm_route_mux_sva

bind pprm_route_mux pprm_route_mux_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// ==== verification/pprm_far_model.sv ====
/* Far side: peripherals drive random levels every cycle.
   Undriven pins float to a level that changes each cycle. */
`timescale 1ns/10ps
module pprm_far_model (
   // Clock and peripheral drive
   input  wire logic                       clk,
   output logic [6:0]                      eventLine,
   output logic [5:0]                      lutOut,
   output pprm_pkg::pprm_ser_drive_s [5:0] serDrive,
   // Pin wires
   input  wire logic [6:0][7:0]            pinOut,
   input  wire logic [6:0][7:0]            pinOe,
   output logic [6:0][7:0]                 pinIn
);
   integer          seed = 32'hb237432e;
   logic [6:0][7:0] ext = '0;
   initial {eventLine, lutOut, serDrive} = '0;
   always @(posedge clk) begin
      eventLine <= 7'($random(seed));
      lutOut <= 6'($random(seed));
      serDrive <= 24'($random(seed));
      ext <= 56'({$random(seed), $random(seed)});
   end
   assign pinIn = (pinOut & pinOe) | (ext & ~pinOe);
endmodule // pprm_far_model

// ==== verification/pprm_route_mux_test.sv ====
/* Self-checking bench of pprm_route_mux with the random far-side model.
   Assumes the zero-wait APB, one-cycle pin outputs and three-flop pin inputs of the design. */
`timescale 1ns/10ps
module pprm_route_mux_test;
   localparam logic [3:0][7:0] MSK = {pprm_pkg::SER_ROUTE_B_MASK, pprm_pkg::SER_ROUTE_A_MASK,
                                      pprm_pkg::LUT_ROUTE_MASK, pprm_pkg::EVT_ROUTE_MASK};
   localparam logic [3:0][7:0] RST = {pprm_pkg::SER_ROUTE_B_RST, pprm_pkg::SER_ROUTE_A_RST,
                                      pprm_pkg::LUT_ROUTE_RST, pprm_pkg::EVT_ROUTE_RST};
   logic                           clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic [3:0]                     pstrb = 4'h1;
   logic [5:0]                     serRx, serClkIn;
   logic [2:0][6:0][7:0]           pinHist;
   logic                           pwrite = 1'b0, pready, pslverr;
   logic [11:0]                    paddr = 12'h000;
   logic [31:0]                    pwdata = 32'h0, prdata;
   logic [6:0]                     eventLine;
   logic [5:0]                     lutOut;
   logic [5:0][2:0]                lutIn;
   pprm_pkg::pprm_ser_drive_s [5:0] serDrive;
   logic [6:0][7:0]                pinIn, pinOut, pinOe;
   integer                         failCount = 0, nChecks = 0, seed = 32'hb237432e;

   pprm_route_mux i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .eventLine, .lutOut, .lutIn, .serDrive, .serRx,
      .serClkIn, .pinIn, .pinOut, .pinOe);
   pprm_far_model i_far (.clk, .eventLine, .lutOut, .serDrive, .pinOut, .pinOe, .pinIn);

   always #20 clk = ~clk;

   // Pin levels of the last three edges, newest first
   always @(posedge clk) pinHist <= {pinHist[1:0], pinIn};

   task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrapUp();
      if (failCount == 0 && nChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Entered just after a rising edge; the caller releases the bus
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic err);
      integer n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      if (n == 16) begin
         failCount++;
         wrapUp();
      end
   endtask

   // Pin drive expected from routing r; later owners override earlier ones
   function automatic void predict(input logic [3:0][7:0] r, output logic [6:0][7:0] eo, ee);
      int         p, b;
      logic [1:0] c;
      eo = '0;
      ee = '0;
      for (int i = 0; i < 7; i++) begin
         b = r[0][i] ? 7 : 2;
         {ee[i][b], eo[i][b]} = {!(r[0][i] && i == 5), eventLine[i]};
      end
      for (int k = 0; k < 6; k++) begin
         p = pprm_pkg::LUT_PORT[k];
         b = r[1][k] ? 6 : 3;
         {ee[p][b], eo[p][b]} = {!(r[1][k] && k == 3), lutOut[k]};
      end
      for (int ch = 0; ch < 6; ch++) begin
         p = pprm_pkg::SER_PORT[ch];
         c = (ch == 5) ? r[3][3:2] : 2'(r[2] >> (2 * ch));
         b = c[0] ? 4 : 0;
         if (ch != 4 && !c[1]) begin
            {ee[p][b], eo[p][b]} = {1'b1, serDrive[ch].tx};
            if (ch != 2 || !c[0]) begin
               {ee[p][b+2], eo[p][b+2]} = {serDrive[ch].clkOe, serDrive[ch].clkOut};
               {ee[p][b+3], eo[p][b+3]} = {1'b1, serDrive[ch].dir};
            end
         end
      end
   endfunction

   // Pin-fed inputs expected from routing r and pin levels h seen two edges earlier
   function automatic logic [29:0] predictIn(input logic [3:0][7:0] r,
                                             input logic [6:0][7:0] h);
      logic [5:0][2:0] li;
      logic [5:0]      rx, ck;
      int              p, b;
      logic [1:0]      c;
      li = '0;
      rx = '0;
      ck = '0;
      for (int k = 0; k < 6; k++) begin
         if (!(r[1][k] && k == 3)) li[k] = h[pprm_pkg::LUT_PORT[k]][2:0];
      end
      for (int ch = 0; ch < 6; ch++) begin
         p = pprm_pkg::SER_PORT[ch];
         c = (ch == 5) ? r[3][3:2] : 2'(r[2] >> (2 * ch));
         b = c[0] ? 4 : 0;
         if (ch != 4 && !c[1]) begin
            rx[ch] = h[p][b+1];
            ck[ch] = (ch != 2 || !c[0]) && h[p][b+2];
         end
      end
      return {li, rx, ck};
   endfunction

   initial begin
      logic [31:0]     q;
      logic            err;
      logic [3:0][7:0] r, v;
      logic [6:0][7:0] eo, ee;
      r = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 12'h010, 8'h00, q, err);
      check("unmapped", {q, err}, 56'h1);
      for (int it = 0; it < 24; it++) begin
         v = $random(seed);
         if (it < 4) v[3:2] = {8{2'(it)}};
         for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 8'h00, q, err);
            check("register", q, 56'(r[i]));
            apb(1'b1, 12'(4 * i), v[i], q, err);
         end
         r = v & MSK;
         psel <= 1'b0;
         penable <= 1'b0;
         @(negedge clk);
         predict(r, eo, ee);
         @(negedge clk);
         check("pin enable", pinOe, ee);
         check("pin level", pinOut & ee, eo & ee);
         check("pin input", {lutIn, serRx, serClkIn}, 56'(predictIn(r, pinHist[2])));
         @(posedge clk);
      end
      // Mid-run reset restores every register; a write with no byte lane is ignored
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      pstrb <= 4'h0;
      apb(1'b1, 12'h000, 8'h7f, q, err);
      pstrb <= 4'h1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'(4 * i), 8'h00, q, err);
         check("reset value", q, 56'(RST[i]));
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
      predict(RST, eo, ee);
      @(negedge clk);
      check("reset pin enable", pinOe, ee);
      wrapUp();
   end
endmodule // pprm_route_mux_test
